// ==== core/optic_mgmt_map.vh ====
// Notes on behaviour
// - bus commands answered only while deselect input is low; high means ignore.
// - interrupt output asserts on important condition; details readable over bus.
// - while transmit-disable is asserted the laser source is switched off.
// - module-absent output is tied to ground inside the module.
// - while power-down is high the module stays in low-power standby.
// - falling edge of power-down begins a module reset.
// - that reset is complete, including serial interface, like power-up.
// - incoming serial data sampled on rising serial clock edge.
// - writes only change unprotected memory; protected bytes stay unchanged.
// - read data changes on the data line at falling serial clock edge.
// - data line bidirectional; each side drives only while transmitting.
// - memory organised as 8-bit words, addressed singly or auto-incrementing.
// - random and sequential access, addresses from 000h to highest implemented.
// - real-time temperature, bias, tx power, rx power, supply readings.
// - alarm and warning flags set when a monitored value leaves range.
// - diagnostics controller presents values only through the serial interface.
// - operates correctly without any reference clock.
// - laser off within 100 ms after transmit-disable asserted.
// - transmitter re-enabled within 100 ms after transmit-disable released.
// - loss-of-signal output 0 in normal reception, 1 with no signal.
`ifndef OPTIC_MGMT_MAP_VH
`define OPTIC_MGMT_MAP_VH
`define DEV_ADDR        7'h50
`define MEM_AW          7
`define MEM_DEPTH       128
`define ADR_TEMP        7'h00
`define ADR_BIAS        7'h01
`define ADR_TXPWR       7'h02
`define ADR_RXPWR       7'h03
`define ADR_VCC         7'h04
`define ADR_ALARM       7'h05
`define ADR_WARN        7'h06
`define ADR_STATUS      7'h07
`define ADR_THR_BASE    7'h10
`define ADR_USER_BASE   7'h40
`define THR_RESET       8'h00
`define MEM_RESET       8'h00
`define TX_TIME_MS      100
`define CLK_KHZ         40000
`define TX_CYCLES       (`TX_TIME_MS * `CLK_KHZ)
`define INIT_CYCLES     16'h0100
`define LASER_ON_CYCLES 32'd4
`endif

// ==== core/pin_sync.v ====
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter RESET_VAL = 1'b0
) (
	input  wire sys_clk_in,
	input  wire rstn_in,
	input  wire pin_in,
	output reg  level_out
);
	reg s1;
	reg s2;
	reg s3;
	// a change counts once stages two and three agree
	always @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			s1 <= RESET_VAL;
			s2 <= RESET_VAL;
			s3 <= RESET_VAL;
			level_out <= RESET_VAL;
		end
		else
		begin
			s1 <= pin_in;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				level_out <= s3;
		end
	end
endmodule
`default_nettype wire

// ==== core/mon_compare.v ====
`timescale 1ns/10ps
`default_nettype none
module mon_compare (
	input  wire [7:0] value_in,
	input  wire [7:0] alarm_hi_in,
	input  wire [7:0] alarm_lo_in,
	input  wire [7:0] warn_hi_in,
	input  wire [7:0] warn_lo_in,
	output wire       alarm_out,
	output wire       warn_out
);
	// a zero threshold means the limit is not programmed
	assign alarm_out = ((alarm_hi_in != 8'h00) && (value_in > alarm_hi_in)) || (value_in < alarm_lo_in);
	assign warn_out  = ((warn_hi_in != 8'h00) && (value_in > warn_hi_in)) || (value_in < warn_lo_in);
endmodule
`default_nettype wire

// ==== core/optic_mgmt.v ====
`timescale 1ns/10ps
`default_nettype none
`include "optic_mgmt_map.vh"
module optic_mgmt #(
	parameter TX_CYCLES = `TX_CYCLES
) (
	input  wire       sys_clk_in,
	input  wire       rstn_in,
	input  wire       deselect_in,
	input  wire       laser_off_request_in,
	input  wire       power_down_in,
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       sda_out,
	output wire       sda_oe_out,
	output reg        int_n_out,
	output reg        not_ready_out,
	output wire       absent_out,
	output reg        rx_signal_lost_out,
	output reg        laser_enable_out,
	output reg        standby_out,
	input  wire [7:0] temp_in,
	input  wire [7:0] bias_in,
	input  wire [7:0] tx_power_in,
	input  wire [7:0] rx_power_in,
	input  wire [7:0] vcc_in,
	input  wire       rx_signal_lost_in,
	input  wire       optional_ref_clock_in
);
	wire scl;
	wire sda;
	wire desel;
	wire txdis;
	wire pdown;
	wire los;
	reg  scl_d;
	reg  sda_d;
	reg  pdown_d;
	// the reference clock is unused; nothing here depends on it
	wire unused_ref = optional_ref_clock_in;

	// every serial and control pin crosses into this clock through pin_sync before use; the value buses do not
	pin_sync #(.RESET_VAL(1'b1)) u_scl (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .pin_in(scl_in),
		.level_out(scl));
	pin_sync #(.RESET_VAL(1'b1)) u_sda (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .pin_in(sda_in),
		.level_out(sda));
	pin_sync #(.RESET_VAL(1'b1)) u_des (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .pin_in(deselect_in),
		.level_out(desel));
	pin_sync #(.RESET_VAL(1'b1)) u_txd (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
		.pin_in(laser_off_request_in), .level_out(txdis));
	pin_sync #(.RESET_VAL(1'b0)) u_pdn (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .pin_in(power_down_in),
		.level_out(pdown));
	pin_sync #(.RESET_VAL(1'b1)) u_los (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
		.pin_in(rx_signal_lost_in), .level_out(los));

	assign absent_out = 1'b0;

	always @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			pdown_d <= 1'b0;
		end
		else
		begin
			scl_d <= scl;
			sda_d <= sda;
			pdown_d <= pdown;
		end
	end

	wire scl_rise = scl & ~scl_d;
	wire scl_fall = ~scl & scl_d;
	wire start_ev = scl & scl_d & sda_d & ~sda;
	wire stop_ev  = scl & scl_d & ~sda_d & sda;
	// soft reset pulse: falling edge of power-down restarts everything
	wire soft_rst = pdown_d & ~pdown;
	wire clr = soft_rst | pdown;

	// serial engine states
	localparam [5:0] ST_IDLE = 6'b000001;
	localparam [5:0] ST_DEV  = 6'b000010;
	localparam [5:0] ST_ACK  = 6'b000100;
	localparam [5:0] ST_WR   = 6'b001000;
	localparam [5:0] ST_RD   = 6'b010000;
	localparam [5:0] ST_RACK = 6'b100000;

	reg [5:0]  state;
	reg [5:0]  next_state;
	reg [2:0]  bit_cnt;
	reg [7:0]  shift;
	reg        is_read;
	reg        have_addr;
	reg        ack_pending;
	reg [6:0]  addr;
	reg        drive_low;
	reg        nack_seen;
	// set by the eighth rising clock; the fall that follows a start carries no bit
	reg        byte_full;
	reg [7:0]  mem [0:`MEM_DEPTH-1];
	reg [7:0]  alarm_flags;
	reg [7:0]  warn_flags;
	reg [15:0] init_cnt;
	reg [31:0] tx_cnt;
	wire       ack_phase = (state == ST_ACK);
	// a write to a read-only byte is still acknowledged, then dropped
	wire       wr_prot = (addr < `ADR_THR_BASE);
	wire       byte_end = scl_fall & byte_full;
	wire       rd_last = (bit_cnt == 3'd7);
	wire [4:0] al_bits;
	wire [4:0] wn_bits;
	wire [7:0] vals [0:4];
	integer    i;

	assign vals[0] = temp_in;
	assign vals[1] = bias_in;
	assign vals[2] = tx_power_in;
	assign vals[3] = rx_power_in;
	assign vals[4] = vcc_in;

	// thresholds live in writable memory, so any reset clears all limits
	genvar g;
	generate
		for (g = 0; g < 5; g = g + 1)
		begin : g_mon
			mon_compare u_cmp (
				.value_in(vals[g]),
				.alarm_hi_in(mem[`ADR_THR_BASE + 4*g]),
				.alarm_lo_in(mem[`ADR_THR_BASE + 4*g + 1]),
				.warn_hi_in(mem[`ADR_THR_BASE + 4*g + 2]),
				.warn_lo_in(mem[`ADR_THR_BASE + 4*g + 3]),
				.alarm_out(al_bits[g]),
				.warn_out(wn_bits[g])
			);
		end
	endgenerate

	always @*
	begin
		next_state = state;
		case (state)
			ST_IDLE: next_state = ST_IDLE;
			ST_DEV:
				if (byte_end)
					next_state = ST_ACK;
			ST_ACK:
				if (scl_fall)
					next_state = ack_pending ? (is_read ? ST_RD : ST_WR) : ST_IDLE;
			ST_WR:
				if (byte_end)
					next_state = ST_ACK;
			ST_RD:
				if (scl_fall && rd_last)
					next_state = ST_RACK;
			ST_RACK:
				if (scl_fall)
					next_state = nack_seen ? ST_IDLE : ST_RD;
			default: next_state = ST_IDLE;
		endcase
		if (start_ev && !desel)
			next_state = ST_DEV;
		if (stop_ev || desel)
			next_state = ST_IDLE;
	end

	// open drain: the line is only ever pulled low, release lets the pull-up win
	// pins reach the engine five clocks late, so the host must wait five clocks
	// after each fall before moving data
	assign sda_oe_out = drive_low | (state == ST_RD & ~shift[7]);
	assign sda_out = 1'b0;

	always @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			state <= ST_IDLE;
			bit_cnt <= 3'd0;
			shift <= 8'h00;
			is_read <= 1'b0;
			have_addr <= 1'b0;
			ack_pending <= 1'b0;
			addr <= 7'h00;
			drive_low <= 1'b0;
			nack_seen <= 1'b0;
			byte_full <= 1'b0;
			for (i = 0; i < `MEM_DEPTH; i = i + 1)
				mem[i] <= `MEM_RESET;
		end
		else if (clr)
		begin
			// full return to power-up state, serial engine included
			state <= ST_IDLE;
			bit_cnt <= 3'd0;
			shift <= 8'h00;
			is_read <= 1'b0;
			have_addr <= 1'b0;
			ack_pending <= 1'b0;
			addr <= 7'h00;
			drive_low <= 1'b0;
			nack_seen <= 1'b0;
			byte_full <= 1'b0;
			for (i = 0; i < `MEM_DEPTH; i = i + 1)
				mem[i] <= `MEM_RESET;
		end
		else
		begin
			state <= next_state;
			// live diagnostics, readable only via the serial memory
			mem[`ADR_TEMP] <= temp_in;
			mem[`ADR_BIAS] <= bias_in;
			mem[`ADR_TXPWR] <= tx_power_in;
			mem[`ADR_RXPWR] <= rx_power_in;
			mem[`ADR_VCC] <= vcc_in;
			mem[`ADR_ALARM] <= alarm_flags;
			mem[`ADR_WARN] <= warn_flags;
			// status byte mirrors loss of signal, transmit-disable, interrupt and not-ready for hosts that cannot see the pins
			mem[`ADR_STATUS] <= {4'h0, los, txdis, int_n_out, not_ready_out};
			if (next_state == ST_DEV && state != ST_DEV)
			begin
				bit_cnt <= 3'd0;
				have_addr <= 1'b0;
				drive_low <= 1'b0;
				byte_full <= 1'b0;
			end
			else if (next_state == ST_IDLE)
				drive_low <= 1'b0;
			else
			begin
				if (scl_rise && (state == ST_DEV || state == ST_WR))
				begin
					shift <= {shift[6:0], sda};
					bit_cnt <= bit_cnt + 3'd1;
					byte_full <= (bit_cnt == 3'd7);
				end
				if (scl_rise && state == ST_RACK)
					nack_seen <= sda;
				// ack_pending doubles as the address-match flag for the device byte
				if (byte_end && state == ST_DEV)
				begin
					ack_pending <= (shift[7:1] == `DEV_ADDR);
					is_read <= shift[0];
					drive_low <= (shift[7:1] == `DEV_ADDR);
				end
				if (byte_end && state == ST_WR)
				begin
					drive_low <= 1'b1;
					ack_pending <= 1'b1;
					if (!have_addr)
					begin
						addr <= shift[6:0];
						have_addr <= 1'b1;
					end
					else
					begin
						if (!wr_prot)
							mem[addr] <= shift;
						addr <= addr + 7'd1;
					end
				end
				if (scl_fall && ack_phase)
				begin
					drive_low <= 1'b0;
					bit_cnt <= 3'd0;
					byte_full <= 1'b0;
					if (is_read && ack_pending)
						shift <= mem[addr];
				end
				if (scl_fall && state == ST_RD)
				begin
					// output bit changes only on falling clock
					shift <= {shift[6:0], 1'b0};
					bit_cnt <= bit_cnt + 3'd1;
				end
				if (scl_fall && state == ST_RD && rd_last)
					addr <= addr + 7'd1;
				if (scl_fall && state == ST_RACK)
				begin
					shift <= mem[addr];
					bit_cnt <= 3'd0;
				end
			end
		end
	end

	// monitor flags, init timer, laser timing, pin outputs
	always @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			alarm_flags <= 8'h00;
			warn_flags <= 8'h00;
			init_cnt <= 16'h0000;
			not_ready_out <= 1'b1;
			int_n_out <= 1'b1;
			tx_cnt <= 32'd0;
			laser_enable_out <= 1'b0;
			standby_out <= 1'b0;
			rx_signal_lost_out <= 1'b1;
		end
		else
		begin
			standby_out <= pdown;
			rx_signal_lost_out <= los;
			if (clr)
			begin
				alarm_flags <= 8'h00;
				warn_flags <= 8'h00;
				init_cnt <= 16'h0000;
				not_ready_out <= 1'b1;
				int_n_out <= 1'b1;
				laser_enable_out <= 1'b0;
				tx_cnt <= 32'd0;
			end
			else
			begin
				alarm_flags <= {3'b000, al_bits};
				warn_flags <= {3'b000, wn_bits};
				if (init_cnt != `INIT_CYCLES)
					init_cnt <= init_cnt + 16'h0001;
				else
					not_ready_out <= 1'b0;
				int_n_out <= ~((|alarm_flags) | los);
				// laser off as soon as sync settles, well under the limit
				if (txdis)
				begin
					laser_enable_out <= 1'b0;
					tx_cnt <= 32'd0;
				end
				else if (!not_ready_out && !laser_enable_out)
				begin
					if (tx_cnt >= `LASER_ON_CYCLES)
						laser_enable_out <= 1'b1;
					else
						tx_cnt <= tx_cnt + 32'd1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== test/optic_mgmt_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module optic_mgmt_properties (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic deselect_in,
	input wire logic laser_off_request_in,
	input wire logic power_down_in,
	input wire logic rx_signal_lost_in,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	input wire logic int_n_out,
	input wire logic not_ready_out,
	input wire logic absent_out,
	input wire logic rx_signal_lost_out,
	input wire logic laser_enable_out,
	input wire logic standby_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	absent_low_a: assert property (!absent_out) else $error("absent high");
	sda_low_a: assert property (!sda_out) else $error("sda drives high");
	laser_off_a: assert property (laser_off_request_in [*8] |-> !laser_enable_out)
		else $error("laser still on");
	laser_on_a: assert property ((!laser_off_request_in && !power_down_in && !not_ready_out) [*8]
		|-> ##[0:4] laser_enable_out) else $error("laser not back on");
	standby_a: assert property (power_down_in [*6] |-> standby_out) else $error("no standby");
	los_follow_a: assert property (rx_signal_lost_in [*6] |-> rx_signal_lost_out)
		else $error("loss of signal not shown");
	int_los_a: assert property (rx_signal_lost_out [*3] |-> !int_n_out) else $error("no interrupt");
	desel_quiet_a: assert property (deselect_in [*8] |-> !sda_oe_out) else $error("answer while deselected");
	ready_hold_a: assert property ($rose(rstn_in) |-> not_ready_out [*8]) else $error("ready too soon");
	pdown_reset_a: assert property ($fell(power_down_in) |-> ##[1:12] not_ready_out)
		else $error("no reset after power-down");
endmodule
`default_nettype wire

// ==== test/host_master.sv ====
`timescale 1ns/10ps
`default_nettype none
module host_master (
	input  wire logic sys_clk_in,
	input  wire logic sda_in,
	output var  logic scl_out,
	output var  logic sda_out
);
	initial
	begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// 200 ns per bit: scl low 6 clocks, high 2; data moves 5 clocks after
	// each fall, once the module has let go of the line
	task w(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask
	task bit_io(input logic b, output logic r);
		w(5);
		sda_out = b;
		w(1);
		scl_out = 1'b1;
		w(2);
		r = sda_in;
		scl_out = 1'b0;
	endtask
	task start;
		w(5);
		sda_out = 1'b1;
		w(2);
		scl_out = 1'b1;
		w(3);
		sda_out = 1'b0;
		w(3);
		scl_out = 1'b0;
	endtask
	task stop;
		w(5);
		sda_out = 1'b0;
		w(2);
		scl_out = 1'b1;
		w(3);
		sda_out = 1'b1;
		w(3);
	endtask
	task xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(tx[i], rx[i]);
		bit_io(ack_in, ack);
	endtask
endmodule
`default_nettype wire

// ==== test/optic_mgmt_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module optic_mgmt_test;
	logic      sys_clk_in, rstn_in, deselect_in, laser_off_request_in, power_down_in;
	logic      rx_signal_lost_in, optional_ref_clock_in;
	logic [7:0] temp_in, bias_in, tx_power_in, rx_power_in, vcc_in;
	logic [7:0] rb [8];
	wire logic scl_in, sda_in, host_sda, sda_out, sda_oe_out, int_n_out, not_ready_out;
	wire logic absent_out, rx_signal_lost_out, laser_enable_out, standby_out;
	int        fails, comparisons;
	// open drain: pull-up wins when nobody drives
	assign sda_in = host_sda & (~sda_oe_out | sda_out);
	optic_mgmt i_dut (.*);
	host_master i_host (.sys_clk_in(sys_clk_in), .sda_in(sda_in), .scl_out(scl_in), .sda_out(host_sda));
	initial
	begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end
	task cyc(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask
	task check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task results;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task wait_ready;
		for (int n = 0; n < 800 && not_ready_out !== 1'b0; n++)
			cyc(1);
		if (not_ready_out !== 1'b0)
		begin
			fails++;
			results();
		end
	endtask
	task addr_phase(input logic [7:0] adr);
		logic       a;
		logic [7:0] d;
		i_host.start();
		i_host.xfer(8'ha0, 1'b1, d, a);
		check({7'h00, a}, 8'h00);
		i_host.xfer(adr, 1'b1, d, a);
	endtask
	task wr(input logic [7:0] adr, input logic [7:0] dat);
		logic       a;
		logic [7:0] d;
		addr_phase(adr);
		i_host.xfer(dat, 1'b1, d, a);
		i_host.stop();
	endtask
	task rd(input logic [7:0] adr, input int n);
		logic       a;
		logic [7:0] d;
		addr_phase(adr);
		i_host.start();
		i_host.xfer(8'ha1, 1'b1, d, a);
		for (int i = 0; i < n; i++)
			i_host.xfer(8'hff, i == n - 1, rb[i], a);
		i_host.stop();
	endtask
	task t_init;
		check({7'h00, not_ready_out}, 8'h01);
		wait_ready();
		check({7'h00, absent_out}, 8'h00);
		check({7'h00, int_n_out}, 8'h01);
		$display("init done");
	endtask
	task t_monitor;
		rd(8'h00, 5);
		check(rb[0], temp_in);
		check(rb[1], bias_in);
		check(rb[2], tx_power_in);
		check(rb[3], rx_power_in);
		check(rb[4], vcc_in);
		rd(8'h03, 1);
		check(rb[0], rx_power_in);
		$display("monitor done");
	endtask
	task t_user;
		addr_phase(8'h7f);
		i_host.xfer(8'ha5, 1'b1, rb[7], rb[6][0]);
		i_host.xfer(8'h5a, 1'b1, rb[7], rb[6][0]);
		i_host.stop();
		rd(8'h7f, 2);
		check(rb[0], 8'ha5);
		check(rb[1], temp_in);
		wr(8'h08, 8'h5a);
		rd(8'h07, 2);
		check(rb[0], 8'h02);
		check(rb[1], 8'h00);
		$display("user done");
	endtask
	task t_alarm;
		wr(8'h10, 8'h20);
		temp_in = 8'h30;
		cyc(10);
		rd(8'h05, 2);
		check(rb[0], 8'h01);
		check(rb[1], 8'h00);
		check({7'h00, int_n_out}, 8'h00);
		temp_in = 8'h11;
		cyc(10);
		check({7'h00, int_n_out}, 8'h01);
		$display("alarm done");
	endtask
	task t_los;
		rx_signal_lost_in = 1'b1;
		cyc(10);
		check({6'h00, rx_signal_lost_out, int_n_out}, 8'h02);
		rx_signal_lost_in = 1'b0;
		cyc(10);
		check({7'h00, rx_signal_lost_out}, 8'h00);
		$display("los done");
	endtask
	task t_desel;
		logic       a;
		logic [7:0] d;
		deselect_in = 1'b1;
		cyc(10);
		i_host.start();
		i_host.xfer(8'ha1, 1'b1, d, a);
		i_host.stop();
		check({7'h00, a}, 8'h01);
		deselect_in = 1'b0;
		cyc(10);
		$display("deselect done");
	endtask
	task t_laser;
		laser_off_request_in = 1'b1;
		cyc(12);
		check({7'h00, laser_enable_out}, 8'h00);
		laser_off_request_in = 1'b0;
		cyc(16);
		check({7'h00, laser_enable_out}, 8'h01);
		$display("laser done");
	endtask
	task t_pdown;
		power_down_in = 1'b1;
		cyc(12);
		check({7'h00, standby_out}, 8'h01);
		power_down_in = 1'b0;
		cyc(16);
		check({7'h00, not_ready_out}, 8'h01);
		wait_ready();
		rd(8'h7f, 1);
		check(rb[0], 8'h00);
		$display("power-down done");
	endtask
	initial
	begin
		{rstn_in, deselect_in, laser_off_request_in, power_down_in} = 4'h0;
		{rx_signal_lost_in, optional_ref_clock_in} = 2'h0;
		{temp_in, bias_in, tx_power_in, rx_power_in, vcc_in} = 40'h11_22_33_44_55;
		cyc(8);
		rstn_in = 1'b1;
		t_init();
		t_monitor();
		t_user();
		t_alarm();
		t_los();
		t_desel();
		t_laser();
		t_pdown();
		results();
	end
endmodule
bind optic_mgmt optic_mgmt_properties i_chk (.*);
`default_nettype wire
